// ### tmwoc_pkg.sv
// constants, field layout and carrier types of the timer waveform output control
// assumes an 8-bit register set reached over a 32-bit classic Wishbone bus
`default_nettype none

package tmwoc_pkg;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL_A = 6'h2F;
    localparam logic [5:0] IDX_STATUS = 6'h30;
    localparam logic [5:0] IDX_MASK   = 6'h31;
    localparam logic [5:0] IDX_CTRL_B = 6'h33;
    localparam logic [5:0] IDX_CMP_A  = 6'h34;
    localparam logic [5:0] IDX_CMP_B  = 6'h35;
    localparam logic [5:0] IDX_COUNT  = 6'h36;

    // ------------------------------------------------------------------
    // field positions, read masks and reset values
    // ------------------------------------------------------------------
    localparam int F_MODE_A_LO = 6;
    localparam int F_MODE_B_LO = 4;
    localparam int F_WAVE_LO   = 0;
    localparam int F_WAVE_BIT2 = 3;
    localparam int F_ST_OVF    = 1;
    localparam int F_ST_MA     = 2;
    localparam int F_ST_MB     = 3;
    localparam logic [7:0] CTRL_A_RMASK = 8'hF3;
    localparam logic [7:0] CTRL_B_RMASK = 8'h08;
    localparam logic [7:0] STATUS_BITS  = 8'h0E;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] TOP_MAX      = 8'hFF;
    localparam logic [7:0] BOTTOM       = 8'h00;

    // ------------------------------------------------------------------
    // wave modes and output codes
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_MAX  = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FAST_MX = 3'h3;
    localparam logic [2:0] MODE_PC_A    = 3'h5;
    localparam logic [2:0] MODE_FAST_A  = 3'h7;
    localparam logic [1:0] CODE_OFF     = 2'h0;
    localparam logic [1:0] CODE_TOGGLE  = 2'h1;
    localparam logic [1:0] CODE_CLEAR   = 2'h2;
    localparam logic [1:0] CODE_SET     = 2'h3;

    typedef enum logic [1:0] {K_NONPWM, K_FAST, K_PHASE} tmwoc_kind_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tmwoc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } tmwoc_wb_rsp_t;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] top;
        logic       up;
    } tmwoc_cnt_t;

    function automatic tmwoc_kind_t mode_kind(input logic [2:0] m);
        if (m == MODE_FAST_MX || m == MODE_FAST_A)
            return K_FAST;
        if (m == MODE_PC_MAX || m == MODE_PC_A)
            return K_PHASE;
        return K_NONPWM;
    endfunction

endpackage

`default_nettype wire

// ### tmwoc_counter.sv
// count sequence, TOP source, compare reload and overflow event
// assumes the mode and buffered compare values come from the register file
`timescale 1ns/1ns
`default_nettype none

module tmwoc_counter
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [2:0]        mode,
    input  wire logic [7:0]        cmp_a_buf,
    input  wire logic [7:0]        cmp_b_buf,
    output tmwoc_pkg::tmwoc_cnt_t  cnt,
    output logic [7:0]             cmp_a_act,
    output logic [7:0]             cmp_b_act,
    output logic                   ovf
);

    typedef struct packed {
        logic [7:0] value;
        logic       up;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic       ovf;
    } tmwoc_ctr_state_t;

    tmwoc_ctr_state_t        s_reg;
    tmwoc_ctr_state_t        s_next;
    tmwoc_pkg::tmwoc_kind_t  kind;
    logic                    top_from_a;
    logic [7:0]              top;
    logic                    at_top;

    assign kind = tmwoc_pkg::mode_kind(mode);
    assign top_from_a = (mode == tmwoc_pkg::MODE_CTC) || (mode == tmwoc_pkg::MODE_PC_A)
                        || (mode == tmwoc_pkg::MODE_FAST_A);
    assign top = top_from_a ? s_reg.cmp_a : tmwoc_pkg::TOP_MAX;
    assign at_top = (s_reg.value >= top);

    always_comb
    begin
        s_next = s_reg;
        // non-pwm modes load at once, pwm modes at TOP
        if (kind == tmwoc_pkg::K_NONPWM || at_top)
        begin
            s_next.cmp_a = cmp_a_buf;
            s_next.cmp_b = cmp_b_buf;
        end
        if (kind == tmwoc_pkg::K_PHASE)
        begin
            s_next.ovf = !s_reg.up && s_reg.value == tmwoc_pkg::BOTTOM;
            if (s_reg.up)
            begin
                if (at_top)
                begin
                    s_next.up = 1'b0;
                    s_next.value = (s_reg.value == tmwoc_pkg::BOTTOM) ? s_reg.value : s_reg.value - 8'h01;
                end
                else
                    s_next.value = s_reg.value + 8'h01;
            end
            else if (s_reg.value == tmwoc_pkg::BOTTOM)
            begin
                s_next.up = 1'b1;
                s_next.value = (top == tmwoc_pkg::BOTTOM) ? s_reg.value : s_reg.value + 8'h01;
            end
            else
                s_next.value = s_reg.value - 8'h01;
        end
        else
        begin
            s_next.up = 1'b1;
            s_next.value = (s_reg.value == top) ? tmwoc_pkg::BOTTOM : s_reg.value + 8'h01;
            if (mode == tmwoc_pkg::MODE_FAST_A)
                s_next.ovf = (s_reg.value == top);
            else
                s_next.ovf = (s_reg.value == tmwoc_pkg::TOP_MAX);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '{value: tmwoc_pkg::BOTTOM, up: 1'b1, cmp_a: tmwoc_pkg::RESET_BYTE,
                       cmp_b: tmwoc_pkg::RESET_BYTE, ovf: 1'b0};
        else
            s_reg <= s_next;
    end

    assign cnt = '{value: s_reg.value, top: top, up: s_reg.up};
    assign cmp_a_act = s_reg.cmp_a;
    assign cmp_b_act = s_reg.cmp_b;
    assign ovf = s_reg.ovf;

endmodule // tmwoc_counter

`default_nettype wire

// ### tmwoc_channel.sv
// one compare output: pin hand-over and waveform level
// assumes counter state and active compare value on the same clock
`timescale 1ns/1ns
`default_nettype none

module tmwoc_channel
#(
    parameter logic PWM_TOGGLE = 1'b0
)
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire tmwoc_pkg::tmwoc_kind_t  kind,
    input  wire logic                    wave_bit2,
    input  wire logic [1:0]              code,
    input  wire logic [7:0]              cmp,
    input  wire tmwoc_pkg::tmwoc_cnt_t   cnt,
    output logic                         level,
    output logic                         connected
);

    typedef struct packed {
        logic level;
        logic connected;
    } tmwoc_ch_state_t;

    tmwoc_ch_state_t s_reg;
    tmwoc_ch_state_t s_next;
    logic            match;
    logic            at_top;
    logic            tog_ok;

    assign match = (cnt.value == cmp);
    assign at_top = (cnt.value == cnt.top);
    assign tog_ok = (kind == tmwoc_pkg::K_NONPWM) || (PWM_TOGGLE && wave_bit2);

    always_comb
    begin
        s_next = s_reg;
        s_next.connected = (code != tmwoc_pkg::CODE_OFF)
                           && !(code == tmwoc_pkg::CODE_TOGGLE && !tog_ok);
        if (code == tmwoc_pkg::CODE_TOGGLE)
        begin
            if (tog_ok && match)
                s_next.level = !s_reg.level;
        end
        else if (code[1])
        begin
            if (kind == tmwoc_pkg::K_NONPWM)
            begin
                if (match)
                    s_next.level = code[0];
            end
            else if (kind == tmwoc_pkg::K_FAST)
            begin
                if (at_top)
                    s_next.level = !code[0];
                else if (match && cmp != cnt.top)
                    s_next.level = code[0];
            end
            else if (cmp == cnt.top)
            begin
                if (at_top)
                    s_next.level = !code[0];
            end
            else if (match)
                s_next.level = cnt.up ? code[0] : !code[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '{level: 1'b0, connected: 1'b0};
        else
            s_reg <= s_next;
    end

    assign level = s_reg.level;
    assign connected = s_reg.connected;

endmodule // tmwoc_channel

`default_nettype wire

// ### tmwoc_top.sv
// timer waveform output control: register file, interrupt and two compare outputs
// assumes a classic Wishbone master and port logic that honours the hand-over flags
//
// How it works
// - nonzero output code hands pin to waveform, except pwm code 01 on B or on A without bit2
// - channel A non-pwm: off, toggle, clear, set
// - channel B non-pwm: off, toggle, clear, set
// - fast pwm A: clear/set on match, opposite at TOP
// - pwm A code 01 toggles only with bit2
// - phase pwm A: up-match one way, down opposite
// - fast pwm B: 01 reserved, 1x like A
// - phase pwm B: 01 reserved, 1x like A
// - compare equals TOP: skip match, act at TOP
// - control A bits 3:2 read zero
// - three-bit wave mode from both controls
// - normal and ctc TOP, immediate load, flag MAX
// - pwm TOP, reload at TOP, flag placement
// - third mode bit at control B bit 3
`timescale 1ns/1ns
`default_nettype none

module tmwoc_top
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire tmwoc_pkg::tmwoc_wb_req_t wb_req,
    output tmwoc_pkg::tmwoc_wb_rsp_t      wb_rsp,
    output logic                          irq,
    output logic                          compare_out_a,
    output logic                          compare_out_b,
    output logic                          pin_override_a,
    output logic                          pin_override_b
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]               timer_control_a;
        logic                     wave_mode_bit2;
        logic [7:0]               cmp_a_buf;
        logic [7:0]               cmp_b_buf;
        logic [7:0]               status;
        logic [7:0]               mask;
        logic [7:0]               clr_bits;
        tmwoc_pkg::tmwoc_wb_rsp_t rsp;
        logic                     irq;
    } tmwoc_top_state_t;

    tmwoc_top_state_t          s_reg;
    tmwoc_top_state_t          s_next;
    logic [2:0]                wave_mode_field;
    tmwoc_pkg::tmwoc_kind_t    kind;
    logic [1:0]                output_mode_a;
    logic [1:0]                output_mode_b;
    tmwoc_pkg::tmwoc_cnt_t     cnt;
    logic [7:0]                cmp_a_act;
    logic [7:0]                cmp_b_act;
    logic                      ovf_evt;
    logic                      req;
    logic                      commit;
    logic [5:0]                idx;
    logic [7:0]                rd_byte;
    logic [7:0]                wr_byte;
    logic [7:0]                events;

    assign wave_mode_field = {s_reg.wave_mode_bit2,
                              s_reg.timer_control_a[tmwoc_pkg::F_WAVE_LO+1:tmwoc_pkg::F_WAVE_LO]};
    assign kind = tmwoc_pkg::mode_kind(wave_mode_field);
    assign output_mode_a = s_reg.timer_control_a[tmwoc_pkg::F_MODE_A_LO+1:tmwoc_pkg::F_MODE_A_LO];
    assign output_mode_b = s_reg.timer_control_a[tmwoc_pkg::F_MODE_B_LO+1:tmwoc_pkg::F_MODE_B_LO];

    // ------------------------------------------------------------------
    // counter and channels
    // ------------------------------------------------------------------
    tmwoc_counter u_counter
    (
        .clk       (clk),
        .rst       (rst),
        .mode      (wave_mode_field),
        .cmp_a_buf (s_reg.cmp_a_buf),
        .cmp_b_buf (s_reg.cmp_b_buf),
        .cnt       (cnt),
        .cmp_a_act (cmp_a_act),
        .cmp_b_act (cmp_b_act),
        .ovf       (ovf_evt)
    );

    tmwoc_channel #(.PWM_TOGGLE(1'b1)) u_chan_a
    (
        .clk       (clk),
        .rst       (rst),
        .kind      (kind),
        .wave_bit2 (s_reg.wave_mode_bit2),
        .code      (output_mode_a),
        .cmp       (cmp_a_act),
        .cnt       (cnt),
        .level     (compare_out_a),
        .connected (pin_override_a)
    );

    tmwoc_channel #(.PWM_TOGGLE(1'b0)) u_chan_b
    (
        .clk       (clk),
        .rst       (rst),
        .kind      (kind),
        .wave_bit2 (s_reg.wave_mode_bit2),
        .code      (output_mode_b),
        .cmp       (cmp_b_act),
        .cnt       (cnt),
        .level     (compare_out_b),
        .connected (pin_override_b)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign req = wb_req.cyc && wb_req.stb && !s_reg.rsp.ack;
    assign commit = wb_req.cyc && wb_req.stb && s_reg.rsp.ack;
    assign idx = wb_req.adr[7:2];
    assign wr_byte = wb_req.dat[7:0];
    assign events = {4'h0, (cnt.value == cmp_b_act), (cnt.value == cmp_a_act), ovf_evt, 1'b0};

    always_comb
    begin
        unique case (idx)
            tmwoc_pkg::IDX_CTRL_A: rd_byte = s_reg.timer_control_a & tmwoc_pkg::CTRL_A_RMASK;
            tmwoc_pkg::IDX_CTRL_B: rd_byte = {4'h0, s_reg.wave_mode_bit2, 3'h0};
            tmwoc_pkg::IDX_STATUS: rd_byte = s_reg.status;
            tmwoc_pkg::IDX_MASK:   rd_byte = s_reg.mask;
            tmwoc_pkg::IDX_CMP_A:  rd_byte = s_reg.cmp_a_buf;
            tmwoc_pkg::IDX_CMP_B:  rd_byte = s_reg.cmp_b_buf;
            tmwoc_pkg::IDX_COUNT:  rd_byte = cnt.value;
            default:               rd_byte = tmwoc_pkg::RESET_BYTE;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.rsp.ack = req;
        s_next.clr_bits = tmwoc_pkg::RESET_BYTE;
        if (req)
        begin
            s_next.rsp.dat = {24'h000000, wb_req.we ? tmwoc_pkg::RESET_BYTE : rd_byte};
            if (!wb_req.we && idx == tmwoc_pkg::IDX_STATUS)
                s_next.clr_bits = rd_byte;
        end
        if (commit && wb_req.we && wb_req.sel[0])
        begin
            unique case (idx)
                tmwoc_pkg::IDX_CTRL_A: s_next.timer_control_a = wr_byte & tmwoc_pkg::CTRL_A_RMASK;
                tmwoc_pkg::IDX_CTRL_B: s_next.wave_mode_bit2 = wr_byte[tmwoc_pkg::F_WAVE_BIT2];
                tmwoc_pkg::IDX_MASK:   s_next.mask = wr_byte & tmwoc_pkg::STATUS_BITS;
                tmwoc_pkg::IDX_CMP_A:  s_next.cmp_a_buf = wr_byte;
                tmwoc_pkg::IDX_CMP_B:  s_next.cmp_b_buf = wr_byte;
                default:               s_next.mask = s_reg.mask;
            endcase
        end
        // only bits that were reported are cleared, a new event wins
        if (commit && !wb_req.we)
            s_next.status = (s_reg.status & ~s_reg.clr_bits) | (events & tmwoc_pkg::STATUS_BITS);
        else
            s_next.status = s_reg.status | (events & tmwoc_pkg::STATUS_BITS);
        s_next.irq = |(s_next.status & s_next.mask);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '{timer_control_a: tmwoc_pkg::RESET_BYTE, wave_mode_bit2: 1'b0,
                       cmp_a_buf: tmwoc_pkg::RESET_BYTE, cmp_b_buf: tmwoc_pkg::RESET_BYTE,
                       status: tmwoc_pkg::RESET_BYTE, mask: tmwoc_pkg::RESET_BYTE,
                       clr_bits: tmwoc_pkg::RESET_BYTE, rsp: '{ack: 1'b0, dat: 32'h00000000},
                       irq: 1'b0};
        else
            s_reg <= s_next;
    end

    assign wb_rsp = s_reg.rsp;
    assign irq = s_reg.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic nonpwm;
    assign nonpwm = (kind == tmwoc_pkg::K_NONPWM);

    AST_HANDOVER_A: assert property (
        (nonpwm && output_mode_a != tmwoc_pkg::CODE_OFF) ##1 nonpwm |-> pin_override_a)
        else $error("channel A not handed to waveform");

    AST_TOGGLE_A: assert property (
        (nonpwm && output_mode_a == tmwoc_pkg::CODE_TOGGLE && cnt.value == cmp_a_act)
        |=> compare_out_a != $past(compare_out_a))
        else $error("channel A did not toggle on match");

    AST_CLEAR_B: assert property (
        (nonpwm && output_mode_b == tmwoc_pkg::CODE_CLEAR && cnt.value == cmp_b_act)
        |=> !compare_out_b)
        else $error("channel B not cleared on match");

    AST_FAST_TOP_A: assert property (
        (kind == tmwoc_pkg::K_FAST && output_mode_a == tmwoc_pkg::CODE_CLEAR && cnt.value == cnt.top)
        |=> compare_out_a)
        else $error("fast pwm channel A not set at TOP");

    AST_PWM_TOGGLE_OFF: assert property (
        (!nonpwm && output_mode_a == tmwoc_pkg::CODE_TOGGLE && !s_reg.wave_mode_bit2)[*2]
        |-> !pin_override_a)
        else $error("channel A code 01 connected without third mode bit");

    AST_PHASE_UP_A: assert property (
        (kind == tmwoc_pkg::K_PHASE && output_mode_a == tmwoc_pkg::CODE_CLEAR && cnt.up
         && cnt.value == cmp_a_act && cmp_a_act != cnt.top)
        |=> !compare_out_a)
        else $error("phase pwm channel A not cleared on up match");

    AST_RESERVED_B: assert property (
        (!nonpwm && output_mode_b == tmwoc_pkg::CODE_TOGGLE)[*2] |-> !pin_override_b)
        else $error("channel B reserved code drives the pin");

    AST_PHASE_DOWN_B: assert property (
        (kind == tmwoc_pkg::K_PHASE && output_mode_b == tmwoc_pkg::CODE_SET && !cnt.up
         && cnt.value == cmp_b_act && cmp_b_act != cnt.top)
        |=> !compare_out_b)
        else $error("phase pwm channel B not cleared on down match");

    AST_TOP_EQUAL: assert property (
        (kind == tmwoc_pkg::K_FAST && output_mode_a == tmwoc_pkg::CODE_SET && cmp_a_act == cnt.top
         && cnt.value == cnt.top)
        |=> !compare_out_a)
        else $error("match at TOP not overridden by TOP action");

    AST_RESERVED_READ: assert property (
        (s_reg.rsp.ack && !wb_req.we && idx == tmwoc_pkg::IDX_CTRL_A) |-> s_reg.rsp.dat[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");

    AST_MODE_WRITE: assert property (
        (commit && wb_req.we && wb_req.sel[0] && idx == tmwoc_pkg::IDX_CTRL_B)
        |=> wave_mode_field[2] == $past(wr_byte[tmwoc_pkg::F_WAVE_BIT2]))
        else $error("third mode bit not taken from control B");

    AST_NORMAL_WRAP: assert property (
        (wave_mode_field == tmwoc_pkg::MODE_NORMAL && cnt.value == tmwoc_pkg::TOP_MAX)
        ##1 (wave_mode_field == tmwoc_pkg::MODE_NORMAL)
        |-> cnt.value == tmwoc_pkg::BOTTOM ##1 s_reg.status[tmwoc_pkg::F_ST_OVF])
        else $error("normal mode did not wrap and flag at MAX");

    AST_PHASE_FLAG: assert property (
        (kind == tmwoc_pkg::K_PHASE && !cnt.up && cnt.value == tmwoc_pkg::BOTTOM)
        |=> ##[1:2] s_reg.status[tmwoc_pkg::F_ST_OVF])
        else $error("phase pwm overflow flag not set at BOTTOM");

    AST_ACK_PULSE: assert property (
        s_reg.rsp.ack |=> !s_reg.rsp.ack)
        else $error("ack held longer than one cycle");

    COV_FAST_PWM: cover property (
        kind == tmwoc_pkg::K_FAST && pin_override_a ##1 $rose(compare_out_a));
    COV_PHASE_PWM: cover property (
        kind == tmwoc_pkg::K_PHASE && pin_override_b ##1 $fell(compare_out_b));
    COV_IRQ: cover property (
        $rose(irq));

endmodule // tmwoc_top

`default_nettype wire

// ### tmwoc_pin_model.sv
// port pad model for one compare output pin
// assumes a pull-up on the pad while the port driver is switched off
`timescale 1ns/1ns
`default_nettype none

module tmwoc_pin_model
(
    input  wire logic wave,
    input  wire logic handed,
    input  wire logic dir_out,
    input  wire logic port_dat,
    output logic      pad
);
    // driver off: pull-up wins
    assign pad = !dir_out ? 1'b1 : (handed ? wave : port_dat);
endmodule // tmwoc_pin_model

`default_nettype wire

// ### testbench.sv
// self-checking bench of the timer waveform output control
// assumes the design files and the pin model are compiled first
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic                     clk;
    logic                     rst;
    tmwoc_pkg::tmwoc_wb_req_t req;
    tmwoc_pkg::tmwoc_wb_rsp_t rsp;
    logic                     irq;
    logic                     out_a;
    logic                     out_b;
    logic                     ovr_a;
    logic                     ovr_b;
    logic                     dir_reg;
    logic                     pdat;
    logic                     pad_a;
    logic [7:0]               q;
    logic [2:0]               md [6] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h7, 3'h5};
    int                       error_cnt;
    int                       n_compared;
    int                       ha, hb, ea, eb;

    tmwoc_top dut_u (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .irq(irq),
        .compare_out_a(out_a), .compare_out_b(out_b), .pin_override_a(ovr_a), .pin_override_b(ovr_b));
    tmwoc_pin_model pin_u (.wave(out_a), .handed(ovr_a), .dir_out(dir_reg), .port_dat(pdat), .pad(pad_a));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input logic [31:0] got);
        n_compared++;
        if (^got === 1'bx || got < lo || got > hi)
        begin
            error_cnt++;
            $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // one classic cycle, read data left in q
    task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, {i, 2'h0}, 4'h1, {24'h0, d}};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 50);
        if (rsp.ack !== 1'b1)
            error_cnt++;
        q = rsp.dat[7:0];
        req <= '0;
    endtask

    task automatic cfg(input logic [2:0] m, input logic [1:0] c, input logic [7:0] cmp);
        wb(1'b1, tmwoc_pkg::IDX_CMP_A, cmp);
        wb(1'b1, tmwoc_pkg::IDX_CMP_B, cmp);
        wb(1'b1, tmwoc_pkg::IDX_CTRL_B, {4'h0, m[2], 3'h0});
        wb(1'b1, tmwoc_pkg::IDX_CTRL_A, {c, c, 2'h0, m[1:0]});
        // covers a reload at TOP in the slowest mode
        repeat (600) @(posedge clk);
    endtask

    // high time and edges of both outputs
    task automatic meas(input int n);
        logic pa, pb;
        ha = 0; hb = 0; ea = 0; eb = 0;
        @(negedge clk);
        pa = out_a;
        pb = out_b;
        repeat (n)
        begin
            @(negedge clk);
            ha += int'(out_a === 1'b1);
            hb += int'(out_b === 1'b1);
            ea += int'(out_a !== pa);
            eb += int'(out_b !== pb);
            pa = out_a;
            pb = out_b;
        end
    endtask

    task automatic conclude;
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        conclude;
    end

    initial
    begin
        error_cnt = 0; n_compared = 0; rst = 1'b1; req = '0; dir_reg = 1'b0; pdat = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, tmwoc_pkg::IDX_CTRL_A, 8'h00); chk("ctrl_a reset", 8'h00, q);
        wb(1'b1, tmwoc_pkg::IDX_CTRL_A, 8'hFF); wb(1'b0, tmwoc_pkg::IDX_CTRL_A, 8'h00);
        chk("ctrl_a read", 8'hF3, q);
        wb(1'b1, tmwoc_pkg::IDX_CTRL_B, 8'hFF); wb(1'b0, tmwoc_pkg::IDX_CTRL_B, 8'h00);
        chk("ctrl_b read", 8'h08, q);
        wb(1'b1, tmwoc_pkg::IDX_MASK, 8'hFF); wb(1'b0, tmwoc_pkg::IDX_MASK, 8'h00);
        chk("mask read", 8'h0E, q);
        wb(1'b1, 6'h3F, 8'hFF); wb(1'b0, 6'h3F, 8'h00); chk("unmapped", 8'h00, q);
        for (int i = 0; i < 6; i++)
            for (int c = 0; c < 4; c++)
            begin
                cfg(md[i], 2'(c), 8'h20);
                chk("override a", {7'h0, c != 0 && !(md[i][0] && c == 1 && !md[i][2])}, {7'h0, ovr_a});
                chk("override b", {7'h0, c != 0 && !(md[i][0] && c == 1)}, {7'h0, ovr_b});
            end
        cfg(3'h0, tmwoc_pkg::CODE_SET, 8'h10); chk("set a", 8'h01, {7'h0, out_a});
        chk("set b", 8'h01, {7'h0, out_b});
        cfg(3'h0, tmwoc_pkg::CODE_CLEAR, 8'h10); chk("clear a", 8'h00, {7'h0, out_a});
        chk("clear b", 8'h00, {7'h0, out_b});
        cfg(3'h0, tmwoc_pkg::CODE_TOGGLE, 8'h10); meas(512); rng("toggle a", 2, 2, ea);
        rng("toggle b", 2, 2, eb);
        dir_reg <= 1'b1;
        @(negedge clk); chk("pad driven", {7'h0, out_a}, {7'h0, pad_a});
        dir_reg <= 1'b0;
        @(negedge clk); chk("pad released", 8'h01, {7'h0, pad_a});
        cfg(3'h3, tmwoc_pkg::CODE_CLEAR, 8'h40); meas(256); rng("fast a", 63, 67, ha);
        rng("fast b", 63, 67, hb);
        cfg(3'h3, tmwoc_pkg::CODE_SET, 8'h40); meas(256); rng("fast inv", 189, 193, hb);
        cfg(3'h1, tmwoc_pkg::CODE_CLEAR, 8'h40); meas(510); rng("phase a", 124, 132, ha);
        rng("phase b", 124, 132, hb);
        cfg(3'h1, tmwoc_pkg::CODE_SET, 8'h40); meas(510); rng("phase inv", 378, 386, ha);
        cfg(3'h3, tmwoc_pkg::CODE_CLEAR, 8'hFF); meas(256); rng("fast top", 256, 256, ha);
        cfg(3'h1, tmwoc_pkg::CODE_CLEAR, 8'hFF); meas(510); rng("phase top", 510, 510, hb);
        cfg(3'h7, tmwoc_pkg::CODE_TOGGLE, 8'h3F); meas(256); rng("toggle top a", 4, 4, ea);
        for (int i = 0; i < 6; i++)
        begin
            cfg(md[i], tmwoc_pkg::CODE_OFF, 8'h20);
            wb(1'b0, tmwoc_pkg::IDX_STATUS, 8'h00);
            repeat (520) @(posedge clk);
            wb(1'b0, tmwoc_pkg::IDX_STATUS, 8'h00);
            chk("overflow", {6'h0, md[i] != 3'h2, 1'b0}, q & 8'h02);
        end
        cfg(3'h2, tmwoc_pkg::CODE_OFF, 8'h20);
        repeat (40)
        begin
            wb(1'b0, tmwoc_pkg::IDX_COUNT, 8'h00); rng("ctc count", 0, 32, {24'h0, q});
        end
        cfg(3'h0, tmwoc_pkg::CODE_OFF, 8'h20);
        wb(1'b1, tmwoc_pkg::IDX_MASK, 8'h02); wb(1'b0, tmwoc_pkg::IDX_STATUS, 8'h00);
        repeat (300) @(posedge clk);
        chk("irq raised", 8'h01, {7'h0, irq});
        wb(1'b0, tmwoc_pkg::IDX_STATUS, 8'h00); chk("status read", 8'h0E, q & 8'h0E);
        @(negedge clk); chk("irq cleared", 8'h00, {7'h0, irq});
        wb(1'b1, tmwoc_pkg::IDX_MASK, 8'h00);
        repeat (300) @(posedge clk);
        chk("irq masked", 8'h00, {7'h0, irq});
        conclude;
    end
endmodule // testbench

`default_nettype wire
